// ### rtl/sram_host_consts.vh
`ifndef SRAM_HOST_CONSTS_VH
`define SRAM_HOST_CONSTS_VH

// Geometry
`define ADDR_W 18
`define DATA_W 8

// Clock period and device timing in ns
`define CLK_PERIOD_NS 50
`define T_RC_NS 45
`define T_AA_NS 45
`define T_DOE_NS 22
`define T_HZOE_NS 18
`define T_WC_NS 45
`define T_SCE_NS 35
`define T_PWE_NS 35
`define T_WRITE_DATA_SETUP_NS 25
`define T_WRITE_TO_FLOAT_DELAY_NS 18

// Least times round up to whole cycles, never below one
`define CYC_UP(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
   (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define RD_CYC `CYC_UP(`T_RC_NS)
`define WR_CYC `CYC_UP(`T_WRITE_TO_FLOAT_DELAY_NS + `T_WRITE_DATA_SETUP_NS)
`define FLOAT_CYC `CYC_UP(`T_HZOE_NS)

// Idle pin levels
`define PRI_SEL_IDLE 1'b1
`define SEC_SEL_IDLE 1'b0

`endif

// ### rtl/sram_pin_sync.v
`timescale 1ns/1ns
module sram_pin_sync (
   // Clock and reset
   input wire i_clock,
   input wire i_arst_n,
   // Pin side
   input wire [7:0] i_async,
   // Clock side
   output wire [7:0] o_sync
);
   reg [7:0] meta_r;
   reg [7:0] sync_r;

   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta_r <= 8'h00;
         sync_r <= 8'h00;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;
endmodule // sram_pin_sync

// ### rtl/sram_host_ctrl.v
`timescale 1ns/1ns
`include "sram_host_consts.vh"

// Functional notes
// - Read: write strobe high, selected, output gate low; device drives data.
// - Write data held stable around the edge that ends the write.
// - Host never drives data pins while the device may drive them.
// - Write strobe at least float delay plus data setup long.
// - Address valid no later than both selects become asserted.
module sram_host_ctrl (
   // Clock and reset
   input wire i_clock,
   input wire i_arst_n,
   // User request
   input wire i_req,
   input wire i_we,
   input wire [17:0] i_addr,
   input wire [7:0] i_wdata,
   output wire o_ready,
   output reg o_rvalid,
   output reg [7:0] o_rdata,
   // Memory pins
   output reg [17:0] o_addr,
   output reg o_primary_select_low,
   output reg o_secondary_select_high,
   output reg o_we_n,
   output reg o_oe_n,
   output reg [7:0] o_data,
   output reg o_data_oe,
   input wire [7:0] i_data
);

   // Controller states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RD = 3'h1;
   localparam [2:0] ST_WR = 3'h2;
   localparam [2:0] ST_WR_END = 3'h3;
   localparam [2:0] ST_FLOAT = 3'h4;

   // Cycle counts, cut to the counter width on purpose
   localparam integer RD_CYC_I = `RD_CYC;
   localparam integer WR_CYC_I = `WR_CYC;
   localparam integer FLOAT_CYC_I = `FLOAT_CYC;
   localparam [3:0] RD_CNT = RD_CYC_I[3:0];
   localparam [3:0] WR_CNT = WR_CYC_I[3:0];
   localparam [3:0] FLOAT_CNT = FLOAT_CYC_I[3:0];
   // Two synchroniser cycles on top of the access time
   localparam [3:0] RD_TOTAL = RD_CNT + 4'h2;

   // State and counter
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] cnt_r;
   reg [3:0] cnt_nxt;
   // Next values of the registered outputs
   reg rvalid_nxt;
   reg [7:0] rdata_nxt;
   reg [17:0] addr_nxt;
   reg pri_sel_nxt;
   reg sec_sel_nxt;
   reg we_n_nxt;
   reg oe_n_nxt;
   reg [7:0] data_nxt;
   reg data_oe_nxt;
   // Data pins after two flip-flops
   wire [7:0] data_sync;

   // Last cycle of a count
   function cnt_last(input [3:0] cnt);
      begin
         cnt_last = (cnt == 4'h1);
      end
   endfunction

   // One step down, never below zero
   function [3:0] cnt_dec(input [3:0] cnt);
      begin
         if (cnt == 4'h0) begin
            cnt_dec = 4'h0;
         end else begin
            cnt_dec = cnt - 4'h1;
         end
      end
   endfunction

   // Select pin pair: both asserted or both at idle level
   function [1:0] sel_pins(input active);
      begin
         if (active) begin
            sel_pins = 2'b01;
         end else begin
            sel_pins = {`PRI_SEL_IDLE, `SEC_SEL_IDLE};
         end
      end
   endfunction

   // Data pins pass two flip-flops before any logic reads them
   sram_pin_sync u_sync (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_async(i_data),
      .o_sync(data_sync)
   );

   // A request is taken on any edge that finds the controller idle
   assign o_ready = (state_r == ST_IDLE);

   // Next state and next pin levels
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      rvalid_nxt = 1'b0;
      rdata_nxt = o_rdata;
      addr_nxt = o_addr;
      pri_sel_nxt = o_primary_select_low;
      sec_sel_nxt = o_secondary_select_high;
      we_n_nxt = o_we_n;
      oe_n_nxt = o_oe_n;
      data_nxt = o_data;
      data_oe_nxt = o_data_oe;
      case (state_r)
         ST_IDLE: begin
            if (i_req) begin
               // Address set together with selects, never after
               addr_nxt = i_addr;
               {pri_sel_nxt, sec_sel_nxt} = sel_pins(1'b1);
               if (i_we) begin
                  // Output gate high during write so device never drives
                  oe_n_nxt = 1'b1;
                  we_n_nxt = 1'b0;
                  data_nxt = i_wdata;
                  data_oe_nxt = 1'b1;
                  cnt_nxt = WR_CNT;
                  state_nxt = ST_WR;
               end else begin
                  we_n_nxt = 1'b1;
                  oe_n_nxt = 1'b0;
                  data_oe_nxt = 1'b0;
                  cnt_nxt = RD_TOTAL;
                  state_nxt = ST_RD;
               end
            end
         end
         ST_RD: begin
            if (cnt_last(cnt_r)) begin
               rdata_nxt = data_sync;
               rvalid_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               {pri_sel_nxt, sec_sel_nxt} = sel_pins(1'b0);
               cnt_nxt = FLOAT_CNT;
               state_nxt = ST_FLOAT;
            end else begin
               cnt_nxt = cnt_dec(cnt_r);
            end
         end
         ST_WR: begin
            if (cnt_last(cnt_r)) begin
               // Strobe ends the write; data stays one more cycle
               we_n_nxt = 1'b1;
               state_nxt = ST_WR_END;
            end else begin
               cnt_nxt = cnt_dec(cnt_r);
            end
         end
         ST_WR_END: begin
            // Release data after hold; output gate stays high
            data_oe_nxt = 1'b0;
            {pri_sel_nxt, sec_sel_nxt} = sel_pins(1'b0);
            state_nxt = ST_IDLE;
         end
         ST_FLOAT: begin
            // Wait for device to float before the next access
            if (cnt_last(cnt_r)) begin
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_dec(cnt_r);
            end
         end
         default: begin
            // Unknown state: release the bus and deselect before going idle
            {pri_sel_nxt, sec_sel_nxt} = sel_pins(1'b0);
            we_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            data_oe_nxt = 1'b0;
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Registers, pins at their idle levels in reset
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         o_rvalid <= 1'b0;
         o_rdata <= 8'h00;
         o_addr <= 18'h00000;
         o_primary_select_low <= `PRI_SEL_IDLE;
         o_secondary_select_high <= `SEC_SEL_IDLE;
         o_we_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_data <= 8'h00;
         o_data_oe <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         o_rvalid <= rvalid_nxt;
         o_rdata <= rdata_nxt;
         o_addr <= addr_nxt;
         o_primary_select_low <= pri_sel_nxt;
         o_secondary_select_high <= sec_sel_nxt;
         o_we_n <= we_n_nxt;
         o_oe_n <= oe_n_nxt;
         o_data <= data_nxt;
         o_data_oe <= data_oe_nxt;
      end
   end
endmodule // sram_host_ctrl

// ### dv/sram_dev_model.sv
`timescale 1ns/1ns
module sram_dev_model (
   // Pins
   input wire [17:0] i_a,
   input wire i_ps,
   input wire i_ss,
   input wire i_we_n,
   input wire i_oe_n,
   input wire [7:0] i_d,
   output wire [7:0] o_q,
   output wire o_en
);
   reg [7:0] mem_r [0:262143];
   wire sel = !i_ps && i_ss;
   wire wr = sel && !i_we_n;
   assign o_en = sel && i_we_n && !i_oe_n;
   assign o_q = mem_r[i_a];
   always @(negedge wr) begin
      mem_r[i_a] <= i_d;
   end
endmodule // sram_dev_model

// ### dv/sram_host_ctrl_sva.sv
`timescale 1ns/1ns
module sram_host_ctrl_sva (
   // Watched ports
   input wire i_clock,
   input wire i_arst_n,
   input wire i_req,
   input wire i_we,
   input wire o_ready,
   input wire o_rvalid,
   input wire [17:0] o_addr,
   input wire o_primary_select_low,
   input wire o_secondary_select_high,
   input wire o_we_n,
   input wire o_oe_n,
   input wire [7:0] o_data,
   input wire o_data_oe
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   wire sel = !o_primary_select_low && o_secondary_select_high;
   property p_hz; o_data_oe |-> o_oe_n; endproperty
   a_hz: assert property (p_hz) else $error("contention");
   property p_rd; !o_oe_n |-> o_we_n && sel; endproperty
   a_rd: assert property (p_rd) else $error("bad read pins");
   property p_hd; $rose(o_we_n) |-> o_data_oe && $stable(o_data) && sel; endproperty
   a_hd: assert property (p_hd) else $error("data not held");
   property p_ad; sel && $past(sel) |-> $stable(o_addr); endproperty
   a_ad: assert property (p_ad) else $error("address moved");
   property p_wl; $fell(o_we_n) |-> sel && o_oe_n ##1 o_we_n; endproperty
   a_wl: assert property (p_wl) else $error("bad strobe");
   property p_rl; o_ready && i_req && !i_we |-> ##4 o_rvalid; endproperty
   a_rl: assert property (p_rl) else $error("late read");
endmodule // sram_host_ctrl_sva
bind sram_host_ctrl sram_host_ctrl_sva i_sva (.*);

// ### dv/async_sram_access_control_tb_top.sv
`timescale 1ns/1ns
`include "sram_host_consts.vh"
module async_sram_access_control_tb_top;
   reg i_clock = 0;
   reg i_arst_n = 0;
   reg i_req = 0;
   reg i_we = 0;
   reg [17:0] i_addr = 0;
   reg [7:0] i_wdata = 0;
   wire [17:0] o_addr;
   wire [7:0] o_rdata, o_data, dq;
   wire o_ready, o_rvalid, o_primary_select_low, o_secondary_select_high, o_we_n, o_oe_n, o_data_oe, dv;
   wire [7:0] i_data = o_data_oe ? o_data : dv ? dq : ~o_data;
   integer bad_count = 0;
   integer tests_run = 0;
   integer k;
   always #25 i_clock = ~i_clock;
   sram_host_ctrl i_sram_host_ctrl (.*);
   sram_dev_model i_sram_dev_model (.i_a(o_addr), .i_ps(o_primary_select_low), .i_ss(o_secondary_select_high),
      .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_d(i_data), .o_q(dq), .o_en(dv));
   task chk(input [63:0] n, input [7:0] s, input [7:0] e);
      begin
         tests_run = tests_run + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %0s exp %h got %h", n, e, s);
         end
      end
   endtask
   task acc(input w, input [17:0] a, input [7:0] d);
      integer n;
      begin
         @(negedge i_clock);
         for (n = 0; n < 20 && o_ready !== 1'b1; n = n + 1) @(negedge i_clock);
         i_req = 1;
         i_we = w;
         i_addr = a;
         i_wdata = d;
         @(negedge i_clock);
         i_req = 0;
         for (n = 0; n < 9 && w && o_ready !== 1'b1; n = n + 1) @(negedge i_clock);
         if (w) chk("wr_cyc", n[7:0], 8'(`WR_CYC + 1));
         for (n = 0; n < 9 && !w && o_rvalid !== 1'b1; n = n + 1) @(posedge i_clock) #1;
         if (!w) chk("rd_cyc", n[7:0], 8'(`RD_CYC + 2));
         if (!w) chk("rdata", o_rdata, d);
      end
   endtask
   task t_bounds;
      begin
         for (k = 0; k < 4; k = k + 1) acc(1, {9{k[1:0]}}, {4{k[1:0]}} ^ 8'h3c);
         for (k = 0; k < 4; k = k + 1) acc(0, {9{k[1:0]}}, {4{k[1:0]}} ^ 8'h3c);
         $display("done bounds");
      end
   endtask
   task t_over;
      begin
         acc(1, 18'h00100, 8'h11);
         acc(1, 18'h00100, 8'hee);
         acc(0, 18'h00100, 8'hee);
         acc(0, 18'h3ffff, 8'hc3);
         $display("done overwrite");
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", tests_run, bad_count);
         if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   always @(negedge i_clock) chk("contend", {7'h0, o_data_oe && dv}, 8'h00);
   initial begin
      #20000;
      bad_count = bad_count + 1;
      results;
   end
   initial begin
      repeat (6) @(negedge i_clock);
      i_arst_n = 1;
      chk("pins", {3'h0, o_primary_select_low, o_secondary_select_high, o_we_n, o_oe_n, o_data_oe}, 8'h16);
      t_bounds;
      t_over;
      results;
   end
endmodule // async_sram_access_control_tb_top
